/* File: tb/low_voltage_force_limiter_tb.sv */
// Self-checking testbench for the low-voltage force limiter
module low_voltage_force_limiter_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk;                 // 40 MHz clock
	logic        resetn;              // Active-low reset
	logic [7:0]  reg_addr;            // Register address
	logic [31:0] reg_wdata;           // Register write data
	logic        reg_wr;              // Write strobe
	logic        reg_rd;              // Read strobe
	logic [31:0] reg_rdata;           // Read data
	logic        supply_low;          // Supply at or below threshold
	logic        supply_off;          // Supply absent
	logic [7:0]  motor_current;       // Measured current
	logic [7:0]  base_current;        // Base current
	logic [7:0]  inst_current_level;  // Instantaneous alarm level
	logic [6:0]  other_force_limit;   // From host model
	logic        restart;             // Restart pulse
	logic        host_active;         // Host model enable
	logic        lv_warning;          // Outputs of the block
	logic        overload_warning;
	logic        overload_alarm;
	logic        inst_overload_alarm;
	logic        servo_disable;
	logic [6:0]  force_limit;
	logic [3:0]  control_mode;
	int          fail_count;          // Mismatches
	int          checked;             // Comparisons made
	logic [6:0]  prev;                // Last limit seen during the ramp
	logic        warned;              // Overload warning seen during the ramp

	// ----------------------------------------
	// Design and host
	// ----------------------------------------
	low_voltage_force_limiter dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.supply_low(supply_low), .supply_off(supply_off), .motor_current(motor_current),
		.base_current(base_current), .inst_current_level(inst_current_level),
		.other_force_limit(other_force_limit), .restart(restart), .lv_warning(lv_warning),
		.overload_warning(overload_warning), .overload_alarm(overload_alarm),
		.inst_overload_alarm(inst_overload_alarm), .servo_disable(servo_disable),
		.force_limit(force_limit), .control_mode(control_mode));

	lvfl_host_model host (.clk(clk), .host_active(host_active), .lv_warning(lv_warning),
		.other_force_limit(other_force_limit));

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Tests take about 80000 cycles; a hang is cut soon after that
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		give_verdict();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask

	task automatic pulse_restart();
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
	endtask

	// Output selector so one wait task serves every flag
	function automatic logic [6:0] pick(input int s);
		case (s)
			0: return {6'h00, lv_warning};
			1: return {6'h00, overload_warning};
			2: return {6'h00, inst_overload_alarm};
			3: return force_limit;
			4: return {3'h0, control_mode};
			5: return {6'h00, servo_disable};
			default: return {6'h00, overload_alarm};
		endcase
	endfunction

	// Bounded wait for an output to reach a value
	task automatic wait_for(input int s, input logic [6:0] v, input int maxc);
		int n;
		n = 0;
		#1;
		while (pick(s) !== v && n < maxc) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({25'h0, pick(s)}, {25'h0, v});
	endtask

	// Output must keep a value for a number of cycles
	task automatic hold(input int s, input logic [6:0] v, input int cycles);
		logic [6:0] seen;
		seen = v;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			if (pick(s) !== v) seen = pick(s);
		end
		check({25'h0, seen}, {25'h0, v});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fail_count = 0;
		checked = 0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		supply_low = 1'b0;
		supply_off = 1'b0;
		motor_current = 8'h00;
		base_current = 8'hFF;
		inst_current_level = 8'hFF;
		restart = 1'b0;
		host_active = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check({25'h0, force_limit}, 32'h64);
		// Defaults and an unmapped place
		reg_read(lvfl_pkg::ADDR_MODE, 32'h0);
		reg_read(lvfl_pkg::ADDR_LIMIT, 32'h32);
		reg_read(lvfl_pkg::ADDR_RELEASE, 32'h64);
		reg_read(lvfl_pkg::ADDR_WARN, 32'h14);
		reg_read(lvfl_pkg::ADDR_DERATE, 32'h64);
		reg_read(lvfl_pkg::ADDR_HOLD, 32'h14);
		reg_read(8'h20, 32'h0);
		// Out-of-range settings clamp to the range ends
		reg_write(lvfl_pkg::ADDR_LIMIT, 32'h7F);
		reg_read(lvfl_pkg::ADDR_LIMIT, 32'h64);
		reg_write(lvfl_pkg::ADDR_RELEASE, 32'h7D0);
		reg_read(lvfl_pkg::ADDR_RELEASE, 32'h3E8);
		reg_write(lvfl_pkg::ADDR_WARN, 32'h0);
		reg_read(lvfl_pkg::ADDR_WARN, 32'h1);
		reg_write(lvfl_pkg::ADDR_DERATE, 32'h5);
		reg_read(lvfl_pkg::ADDR_DERATE, 32'h0A);
		reg_write(lvfl_pkg::ADDR_DERATE, 32'h64);
		reg_write(lvfl_pkg::ADDR_WARN, 32'h14);
		reg_write(lvfl_pkg::ADDR_MODE, 32'h35);
		reg_read(lvfl_pkg::ADDR_MODE, 32'h05);
		// Short outage below the hold time keeps the servo on
		@(posedge clk);
		supply_off <= 1'b1;
		hold(5, 7'h0, 100);
		supply_off <= 1'b0;
		// Detection off; new mode waits for restart
		@(posedge clk);
		supply_low <= 1'b1;
		reg_write(lvfl_pkg::ADDR_MODE, 32'h13);
		hold(0, 7'h0, 20);
		hold(4, 7'h0, 2);
		check({25'h0, force_limit}, 32'h64);
		// Host mode: warning only, host limits
		pulse_restart();
		host_active <= 1'b1;
		wait_for(4, 7'h3, 4);
		wait_for(0, 7'h1, 4);
		wait_for(3, 7'h1E, 6);
		reg_read(lvfl_pkg::ADDR_STATUS, 32'h110);
		@(posedge clk);
		supply_low <= 1'b0;
		wait_for(0, 7'h0, 4);
		wait_for(3, 7'h64, 6);
		// Self mode: drive limits, then ramps back
		host_active <= 1'b0;
		reg_write(lvfl_pkg::ADDR_RELEASE, 32'h1);
		reg_write(lvfl_pkg::ADDR_LIMIT, 32'h28);
		reg_write(lvfl_pkg::ADDR_MODE, 32'h20);
		pulse_restart();
		motor_current <= 8'hC8;
		@(posedge clk);
		supply_low <= 1'b1;
		wait_for(3, 7'h28, 8);
		reg_read(lvfl_pkg::ADDR_STATUS, 32'h160);
		reg_write(lvfl_pkg::ADDR_LIMIT, 32'h19);
		wait_for(3, 7'h19, 4);
		reg_read(lvfl_pkg::ADDR_EFFLIM, 32'h19);
		@(posedge clk);
		supply_low <= 1'b0;
		prev = force_limit;
		warned = 1'b0;
		// Current stays under the derated base, so nothing accumulates
		repeat (40020) begin
			@(posedge clk);
			#1;
			if (force_limit < prev) check({25'h0, force_limit}, {25'h0, prev});
			prev = force_limit;
			if (overload_warning !== 1'b0) warned = 1'b1;
		end
		check({25'h0, force_limit}, 32'h64);
		check({31'h0, warned}, 32'h0);
		// Heavy current: warning after a fifth of the alarm time
		motor_current <= 8'hFF;
		base_current <= 8'h00;
		wait_for(1, 7'h1, 40020);
		check({31'h0, overload_alarm}, 32'h0);
		// Instantaneous alarm from its own fixed level
		inst_current_level <= 8'h80;
		wait_for(2, 7'h1, 8);
		give_verdict();
	end
endmodule // low_voltage_force_limiter_tb

/* File: tb/lvfl_host_model.sv */
// Host controller model that limits force while the drive warns of low supply
module lvfl_host_model #(
	parameter logic [6:0] HOST_LIMIT = 7'h1E    // Host's own limit while warned, percent
) (
	// Clock
	input  wire logic       clk,
	// Bench control and drive warning
	input  wire logic       host_active,        // Host takes part in limiting
	input  wire logic       lv_warning,         // Low-voltage warning from the drive
	// Limit towards the drive
	output logic      [6:0] other_force_limit = 7'h64  // Host force limit, percent
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Force limit follower
	// ----------------------------------------
	// Full force until the first edge (port initialiser), never an unknown limit
	// Limit only while warned, dropped at once when the warning clears
	// No servo enable port on this block, so current stop is left to the bench
	always @(posedge clk) begin
		if (host_active && lv_warning) begin
			other_force_limit <= HOST_LIMIT;
		end else begin
			other_force_limit <= 7'h64;
		end
	end
endmodule // lvfl_host_model

/* File: verilog/low_voltage_force_limiter.sv */
// Low-voltage force limiter with overload warning and alarm timing
// Notes on behaviour
// - Detect supply at or below threshold, limit
// - Mode off: no detection, no limiting
// - Host mode: detect and raise warning only
// - Self mode: detect and limit force internally
// - Self mode: restore force within release time
// - Limit level 0..100 percent, default 50
// - Release time 0..1000 ms, default 100
// - Warn at percent of alarm time, default 20
// - Warning level 1..100 percent, immediate
// - Overload warning drives warning output
// - Accumulate above derated base current only
// - Derating 10..100, default 100, after restart
// - Instantaneous alarm fixed, ignores settings
// - Derating also shifts warning timing
// - Control mode default speed, after restart
// - Hold time: continue or disable servo
//
// Chosen here: the address-and-strobe port and the address map.
module low_voltage_force_limiter (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Plant measurements
	input  wire logic        supply_low,
	input  wire logic        supply_off,
	input  wire logic [7:0]  motor_current,
	input  wire logic [7:0]  base_current,
	input  wire logic [7:0]  inst_current_level,
	input  wire logic [6:0]  other_force_limit,
	input  wire logic        restart,
	// Outputs to drive and host
	output logic             lv_warning,
	output logic             overload_warning,
	output logic             overload_alarm,
	output logic             inst_overload_alarm,
	output logic             servo_disable,
	output logic      [6:0]  force_limit,
	output logic      [3:0]  control_mode
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_q;   // First stage, read by second only
	logic rst_n_q;      // Synchronised active-low reset

	// Release in two stages, assert at once
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [1:0]  lv_mode_sw_q;     // Written low-voltage mode
	logic [3:0]  ctrl_sw_q;        // Written control mode
	logic [6:0]  limit_q;          // Drop force limit level
	logic [10:0] release_q;        // Release time in ms
	logic [6:0]  warn_q;           // Overload warning level
	logic [6:0]  derate_sw_q;      // Written derating
	logic [10:0] hold_q;           // Power cut hold time
	logic [1:0]  lv_mode_q;        // Active mode, latched at restart
	logic [6:0]  derate_q;         // Active derating, latched at restart

	localparam logic [6:0] PCT_FULL_L = lvfl_pkg::PCT_FULL;  // Local copy for functions

	// Clamp a percent value into its range
	function automatic logic [6:0] clamp_pct(input logic [31:0] v, input logic [6:0] lo);
		if (v[31:7] != 25'h0000000 || v[6:0] > PCT_FULL_L) clamp_pct = PCT_FULL_L;
		else if (v[6:0] < lo) clamp_pct = lo;
		else clamp_pct = v[6:0];
	endfunction

	// Clamp a millisecond value into its range
	function automatic logic [10:0] clamp_ms(input logic [31:0] v, input logic [10:0] lo);
		if (v[31:11] != 21'h000000 || v[10:0] > lvfl_pkg::TIME_MAX) clamp_ms = lvfl_pkg::TIME_MAX;
		else if (v[10:0] < lo) clamp_ms = lo;
		else clamp_ms = v[10:0];
	endfunction

	// Register writes; immediate settings steer logic at once
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lv_mode_sw_q <= lvfl_pkg::RST_LV_MODE;
			ctrl_sw_q    <= lvfl_pkg::RST_CTRL_MODE;
			limit_q      <= lvfl_pkg::RST_LIMIT;
			release_q    <= lvfl_pkg::RST_RELEASE;
			warn_q       <= lvfl_pkg::RST_WARN;
			derate_sw_q  <= lvfl_pkg::RST_DERATE;
			hold_q       <= lvfl_pkg::RST_HOLD;
		end else if (reg_wr) begin
			if (reg_addr == lvfl_pkg::ADDR_MODE) begin
				// Mode 3 is not a valid setting: treated as off
				lv_mode_sw_q <= (reg_wdata[lvfl_pkg::MODE_LV_LSB+:2] == 2'h3) ? 2'h0
				              : reg_wdata[lvfl_pkg::MODE_LV_LSB+:2];
				ctrl_sw_q    <= reg_wdata[lvfl_pkg::MODE_CTRL_LSB+:4];
			end else if (reg_addr == lvfl_pkg::ADDR_LIMIT) begin
				limit_q <= clamp_pct(reg_wdata, 7'h00);
			end else if (reg_addr == lvfl_pkg::ADDR_RELEASE) begin
				release_q <= clamp_ms(reg_wdata, 11'h000);
			end else if (reg_addr == lvfl_pkg::ADDR_WARN) begin
				warn_q <= clamp_pct(reg_wdata, lvfl_pkg::WARN_MIN);
			end else if (reg_addr == lvfl_pkg::ADDR_DERATE) begin
				derate_sw_q <= clamp_pct(reg_wdata, lvfl_pkg::DERATE_MIN);
			end else if (reg_addr == lvfl_pkg::ADDR_HOLD) begin
				hold_q <= clamp_ms(reg_wdata, lvfl_pkg::HOLD_MIN);
			end
		end
	end

	// Restart-only settings copy on the restart pulse
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lv_mode_q    <= lvfl_pkg::RST_LV_MODE;
			derate_q     <= lvfl_pkg::RST_DERATE;
			control_mode <= lvfl_pkg::RST_CTRL_MODE;
		end else if (restart) begin
			lv_mode_q    <= lv_mode_sw_q;
			derate_q     <= derate_sw_q;
			control_mode <= ctrl_sw_q;
		end
	end

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	logic [lvfl_pkg::CYC_PER_MS_W-1:0] pre_q;   // Prescaler
	logic                              ms_tick; // One-cycle enable each ms

	assign ms_tick = (pre_q == lvfl_pkg::CYC_PER_MS_W'(lvfl_pkg::CYC_PER_MS - 1));

	// Free-running divider
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) pre_q <= '0;
		else if (ms_tick) pre_q <= '0;
		else pre_q <= pre_q + 1'b1;
	end

	// ----------------------------------------
	// Low-voltage detection and drop limit
	// ----------------------------------------
	lvfl_pkg::drop_state_type state_q;  // Drop limit state
	logic [10:0] rel_ms_q;              // Release progress in ms
	logic [6:0]  drop_lim;              // Drop limit now applied
	logic        detect_on;             // Detection enabled

	assign detect_on = (lv_mode_q != 2'(lvfl_pkg::LV_OFF));

	// Warning follows supply only while detection is enabled
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) lv_warning <= 1'b0;
		else lv_warning <= detect_on && supply_low;
	end

	// Limit state: enter on warning, ramp out over release time
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q  <= lvfl_pkg::DROP_IDLE;
			rel_ms_q <= '0;
		end else if (lv_mode_q != 2'(lvfl_pkg::LV_SELF)) begin
			state_q  <= lvfl_pkg::DROP_IDLE;
			rel_ms_q <= '0;
		end else begin
			case (state_q)
				lvfl_pkg::DROP_IDLE: begin
					if (lv_warning) state_q <= lvfl_pkg::DROP_LIMIT;
				end
				lvfl_pkg::DROP_LIMIT: begin
					rel_ms_q <= '0;
					if (!lv_warning) state_q <= lvfl_pkg::DROP_RELEASE;
				end
				default: begin
					if (lv_warning) begin
						state_q <= lvfl_pkg::DROP_LIMIT;
					end else if (rel_ms_q >= release_q) begin
						state_q <= lvfl_pkg::DROP_IDLE;
					end else if (ms_tick) begin
						rel_ms_q <= rel_ms_q + 11'h001;
					end
				end
			endcase
		end
	end

	// Linear ramp from limit toward full force, monotone in time
	always_comb begin
		logic [17:0] span;
		span = 18'h00000;
		drop_lim = lvfl_pkg::PCT_FULL;
		if (state_q == lvfl_pkg::DROP_LIMIT) begin
			drop_lim = limit_q;
		end else if (state_q == lvfl_pkg::DROP_RELEASE && rel_ms_q < release_q) begin
			// Operands widened first so the product cannot wrap
			span = (18'(lvfl_pkg::PCT_FULL - limit_q) * 18'(rel_ms_q)) / 18'(release_q);
			drop_lim = limit_q + span[6:0];
		end
	end

	// Effective limit is the smaller of the two
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) force_limit <= lvfl_pkg::PCT_FULL;
		else force_limit <= (drop_lim < other_force_limit) ? drop_lim
		                  : ((other_force_limit > lvfl_pkg::PCT_FULL) ? lvfl_pkg::PCT_FULL
		                  : other_force_limit);
	end

	// ----------------------------------------
	// Power cut hold
	// ----------------------------------------
	logic [10:0] off_ms_q;   // Time supply has been off

	// Disable servo once outage reaches the hold time
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			off_ms_q      <= '0;
			servo_disable <= 1'b0;
		end else if (!supply_off) begin
			off_ms_q      <= '0;
			servo_disable <= 1'b0;
		end else begin
			if (ms_tick && off_ms_q < lvfl_pkg::TIME_MAX) off_ms_q <= off_ms_q + 11'h001;
			if (off_ms_q >= hold_q) servo_disable <= 1'b1;
		end
	end

	// ----------------------------------------
	// Overload detection
	// ----------------------------------------
	// Accumulator counts excess over the derated base current per ms;
	// the alarm trips at a fixed full-scale figure, so derating moves both
	// alarm and warning earlier.
	localparam logic [19:0] ACC_FULL = 20'h186A0;  // Alarm point, arbitrary scale
	logic [19:0] acc_q;       // Overload accumulator
	logic [15:0] thr;         // Derated base current scaled by 100
	logic [15:0] cur_x100;    // Motor current scaled by 100
	logic [26:0] warn_pt;     // Warning point scaled by 100
	logic [26:0] acc_x100;    // Accumulator scaled by 100

	assign thr      = 16'(base_current) * 16'(derate_q);
	assign cur_x100 = 16'(motor_current) * 16'(lvfl_pkg::PCT_FULL);
	assign warn_pt  = 27'(ACC_FULL) * 27'(warn_q);
	assign acc_x100 = 27'(acc_q) * 27'(lvfl_pkg::PCT_FULL);

	// Integrate while above threshold, bleed down otherwise
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) acc_q <= '0;
		else if (ms_tick) begin
			if (cur_x100 > thr) begin
				acc_q <= (acc_q > ACC_FULL - 20'(cur_x100 - thr)) ? ACC_FULL
				       : acc_q + 20'(cur_x100 - thr);
			end else if (acc_q != 20'h00000) begin
				acc_q <= acc_q - 20'h00001;
			end
		end
	end

	// Warning and alarm flags from the accumulator
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			overload_warning <= 1'b0;
			overload_alarm   <= 1'b0;
		end else begin
			overload_warning <= (acc_x100 >= warn_pt);
			overload_alarm   <= (acc_q >= ACC_FULL);
		end
	end

	// Instantaneous alarm uses only its fixed level
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) inst_overload_alarm <= 1'b0;
		else inst_overload_alarm <= (motor_current >= inst_current_level);
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Data stand one cycle after the read strobe, zero otherwise
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) reg_rdata <= '0;
		else if (!reg_rd) reg_rdata <= '0;
		else if (reg_addr == lvfl_pkg::ADDR_MODE)
			reg_rdata <= {26'h0, lv_mode_sw_q, ctrl_sw_q};
		else if (reg_addr == lvfl_pkg::ADDR_LIMIT) reg_rdata <= {25'h0, limit_q};
		else if (reg_addr == lvfl_pkg::ADDR_RELEASE) reg_rdata <= {21'h0, release_q};
		else if (reg_addr == lvfl_pkg::ADDR_WARN) reg_rdata <= {25'h0, warn_q};
		else if (reg_addr == lvfl_pkg::ADDR_DERATE) reg_rdata <= {25'h0, derate_sw_q};
		else if (reg_addr == lvfl_pkg::ADDR_HOLD) reg_rdata <= {21'h0, hold_q};
		else if (reg_addr == lvfl_pkg::ADDR_STATUS)
			reg_rdata <= {23'h0, lv_warning, state_q, lv_mode_q, servo_disable,
			              inst_overload_alarm, overload_alarm, overload_warning};
		else if (reg_addr == lvfl_pkg::ADDR_EFFLIM) reg_rdata <= {25'h0, force_limit};
		else reg_rdata <= '0;   // Unmapped reads zero
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_off_no_warn;
		@(posedge clk) disable iff (!rst_n_q)
		(lv_mode_q == 2'h0) |=> !lv_warning;
	endproperty
	a_off_no_warn: assert property (p_off_no_warn) else $error("warning in off mode");

	property p_warn_follows;
		@(posedge clk) disable iff (!rst_n_q)
		(lv_mode_q != 2'h0 && supply_low) |=> lv_warning;
	endproperty
	a_warn_follows: assert property (p_warn_follows) else $error("low supply missed");

	property p_host_no_limit;
		@(posedge clk) disable iff (!rst_n_q)
		(lv_mode_q == 2'h1) |-> ##1 (state_q == lvfl_pkg::DROP_IDLE);
	endproperty
	a_host_no_limit: assert property (p_host_no_limit) else $error("host mode limited");

	sequence s_self_warn;
		(lv_mode_q == 2'h2) && lv_warning && $stable(lv_mode_q);
	endsequence
	property p_self_limits;
		@(posedge clk) disable iff (!rst_n_q)
		s_self_warn ##1 (lv_mode_q == 2'h2) |-> (state_q == lvfl_pkg::DROP_LIMIT);
	endproperty
	a_self_limits: assert property (p_self_limits) else $error("self mode not limiting");

	property p_limit_bound;
		@(posedge clk) disable iff (!rst_n_q)
		(state_q == lvfl_pkg::DROP_LIMIT) |=> (force_limit <= $past(limit_q));
	endproperty
	a_limit_bound: assert property (p_limit_bound) else $error("limit exceeded");

	property p_ramp_up;
		@(posedge clk) disable iff (!rst_n_q)
		(state_q == lvfl_pkg::DROP_RELEASE && $past(state_q) == lvfl_pkg::DROP_RELEASE
		 && $stable(limit_q) && $stable(release_q)) |-> drop_lim >= $past(drop_lim);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("release not monotone");

	property p_inst;
		@(posedge clk) disable iff (!rst_n_q)
		(motor_current >= inst_current_level) |=> inst_overload_alarm;
	endproperty
	a_inst: assert property (p_inst) else $error("instant alarm missed");

	property p_hold;
		@(posedge clk) disable iff (!rst_n_q)
		!supply_off |=> !servo_disable;
	endproperty
	a_hold: assert property (p_hold) else $error("servo disabled with supply");

	property p_warn_before_alarm;
		@(posedge clk) disable iff (!rst_n_q)
		overload_alarm |-> overload_warning;
	endproperty
	a_warn_before_alarm: assert property (p_warn_before_alarm) else $error("alarm without warn");

endmodule // low_voltage_force_limiter

/* File: verilog/lvfl_pkg.sv */
// Package of constants and types for the low-voltage force limiter
package lvfl_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int CLK_HZ          = 40000000;               // Core clock rate
	localparam int MS_US           = 1000;                   // One millisecond in us
	localparam int CYC_PER_MS      = CLK_HZ / 1000;          // Cycles in one millisecond
	localparam int CYC_PER_MS_W    = 16;                     // Width of millisecond prescaler

	// ----------------------------------------
	// Register offsets (word index = byte address / 4)
	// ----------------------------------------
	localparam logic [7:0] ADDR_MODE     = 8'h00;  // Low-voltage mode and control mode
	localparam logic [7:0] ADDR_LIMIT    = 8'h04;  // Drop force limit level, percent
	localparam logic [7:0] ADDR_RELEASE  = 8'h08;  // Release time, ms
	localparam logic [7:0] ADDR_WARN     = 8'h0C;  // Overload warning level, percent
	localparam logic [7:0] ADDR_DERATE   = 8'h10;  // Base current derating, percent
	localparam logic [7:0] ADDR_HOLD     = 8'h14;  // Power cut hold time, ms
	localparam logic [7:0] ADDR_STATUS   = 8'h18;  // Live status, read only
	localparam logic [7:0] ADDR_EFFLIM   = 8'h1C;  // Effective force limit, read only

	// ----------------------------------------
	// Field positions in the mode register
	// ----------------------------------------
	localparam int MODE_LV_LSB   = 4;    // Low-voltage mode digit, bits 5:4
	localparam int MODE_CTRL_LSB = 0;    // Control mode digit, bits 3:0

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0]  RST_LV_MODE   = 2'h0;    // Detection off
	localparam logic [3:0]  RST_CTRL_MODE = 4'h0;    // Speed control, analog reference
	localparam logic [6:0]  RST_LIMIT     = 7'h32;   // 50 percent
	localparam logic [10:0] RST_RELEASE   = 11'h064; // 100 ms
	localparam logic [6:0]  RST_WARN      = 7'h14;   // 20 percent
	localparam logic [6:0]  RST_DERATE    = 7'h64;   // 100 percent
	localparam logic [10:0] RST_HOLD      = 11'h014; // 20 ms

	// ----------------------------------------
	// Setting ranges
	// ----------------------------------------
	localparam logic [6:0]  PCT_FULL      = 7'h64;   // 100 percent
	localparam logic [6:0]  WARN_MIN      = 7'h01;   // Lowest warning level
	localparam logic [6:0]  DERATE_MIN    = 7'h0A;   // Lowest derating
	localparam logic [10:0] TIME_MAX      = 11'h3E8; // 1000 ms
	localparam logic [10:0] HOLD_MIN      = 11'h014; // 20 ms

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		LV_OFF,     // No detection
		LV_HOST,    // Warn, host limits force
		LV_SELF     // Warn and limit in the drive
	} lv_mode_type;

	typedef enum logic [1:0] {
		DROP_IDLE,     // Full force
		DROP_LIMIT,    // Supply low, limited
		DROP_RELEASE   // Ramping back to full force
	} drop_state_type;

endpackage
